/* File: dual_timer_pkg.sv */
// Purpose: constants for the dual timer with clock select
// Assumes: AXI4-Lite, printed offsets are register indices (byte address = 4 * index)
// Notes: register indices, control bit positions, reset values and divider limits
`default_nettype none
package dual_timer_pkg;
  localparam logic [7:0] IDX_SYSCLK = 8'h0F;
  localparam logic [7:0] IDX_T0_RELOAD = 8'h10;
  localparam logic [7:0] IDX_T0_CTRL = 8'h11;
  localparam logic [7:0] IDX_T1_COUNT = 8'h12;
  localparam logic [7:0] IDX_T1_RELOAD = 8'h13;
  localparam logic [7:0] IDX_T1_CTRL = 8'h14;
  localparam logic [7:0] IDX_T0_COUNT = 8'h20;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h21;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h22;
  localparam int BIT_FAST_HALT = 3;
  localparam int BIT_SRC_SEL = 2;
  localparam int BIT_T_HALT = 6;
  localparam int BIT_T0_EDGE = 5;
  localparam int BIT_T0_SRC = 4;
  localparam int BIT_IRQ_T0 = 0;
  localparam int BIT_IRQ_T1 = 1;
  localparam logic [7:0] SYSCLK_RESET = 8'h0B;
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [3:0] T1_DIV_MAX_CODE = 4'h8;
  localparam logic [7:0] COUNT_TOP = 8'hFF;
  localparam logic [2:0] SYS_LIM_DIV8 = 3'h7;
  localparam logic [2:0] SYS_LIM_DIV4 = 3'h3;
  localparam logic [2:0] SYS_LIM_DIV2 = 3'h1;
  localparam logic [2:0] SYS_LIM_DIV1 = 3'h0;
endpackage : dual_timer_pkg
`default_nettype wire

/* File: dual_timer.sv */
// Purpose: two 8-bit reload timers with prescalers and system clock selection
// Assumes: slow_clk_tick and fast_clk_tick are one-cycle enables of the slow and fast sources
// Notes: registers over AXI4-Lite, sticky overflow flags with mask and one irq output
`default_nettype none
module dual_timer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic slow_clk_tick,
  input wire logic fast_clk_tick,
  input wire logic t0_external_clock_pin,
  output logic fast_osc_enable,
  output logic sys_tick,
  output logic irq
);
  logic [7:0] sysclk_q;
  logic [7:0] t0_reload_q;
  logic [7:0] t0_ctrl_q;
  logic [7:0] t0_count_q;
  logic [7:0] t1_count_q;
  logic [7:0] t1_reload_q;
  logic [7:0] t1_ctrl_q;
  logic [1:0] irq_status_q;
  logic [1:0] irq_mask_q;

  // write channel capture
  logic aw_held_q;
  logic w_held_q;
  logic [9:0] aw_idx_q;
  logic [31:0] wdata_q;
  logic wstrb0_q;
  logic wr_fire;
  logic [7:0] wr_idx;
  logic wr_ok;
  logic wr_hit;

  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready = !w_held_q && !s_axi_bvalid;
  assign wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
  assign wr_idx = aw_idx_q[7:0];
  assign wr_ok = (aw_idx_q[9:8] == 2'h0) && ((wr_idx >= dual_timer_pkg::IDX_SYSCLK &&
    wr_idx <= dual_timer_pkg::IDX_T1_CTRL) || (wr_idx >= dual_timer_pkg::IDX_T0_COUNT &&
    wr_idx <= dual_timer_pkg::IDX_IRQ_MASK));
  assign wr_hit = wr_fire && wstrb0_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_idx_q <= 10'h000;
      wdata_q <= 32'h00000000;
      wstrb0_q <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= dual_timer_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_idx_q <= s_axi_awaddr[11:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb0_q <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? dual_timer_pkg::RESP_OKAY : dual_timer_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  function automatic logic wsel(input logic [7:0] idx);
    wsel = wr_hit && (wr_idx == idx) && (aw_idx_q[9:8] == 2'h0);
  endfunction : wsel

  // control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sysclk_q <= dual_timer_pkg::SYSCLK_RESET;
      t0_reload_q <= dual_timer_pkg::ZERO8;
      t0_ctrl_q <= dual_timer_pkg::ZERO8;
      t1_reload_q <= dual_timer_pkg::ZERO8;
      t1_ctrl_q <= dual_timer_pkg::ZERO8;
      irq_mask_q <= 2'h0;
    end else begin
      if (wsel(dual_timer_pkg::IDX_SYSCLK)) sysclk_q <= {4'h0, wdata_q[3:0]};
      if (wsel(dual_timer_pkg::IDX_T0_RELOAD)) t0_reload_q <= wdata_q[7:0];
      if (wsel(dual_timer_pkg::IDX_T0_CTRL)) t0_ctrl_q <= {1'b0, wdata_q[6:0]};
      if (wsel(dual_timer_pkg::IDX_T1_RELOAD)) t1_reload_q <= wdata_q[7:0];
      if (wsel(dual_timer_pkg::IDX_T1_CTRL)) t1_ctrl_q <= {1'b0, wdata_q[6:0]};
      if (wsel(dual_timer_pkg::IDX_IRQ_MASK)) irq_mask_q <= wdata_q[1:0];
    end
  end

  // system clock: source select, fast halt gates fast ticks, then divide
  logic src_tick;
  logic [2:0] sys_div_q;
  logic [2:0] sys_div_lim;
  assign fast_osc_enable = !sysclk_q[dual_timer_pkg::BIT_FAST_HALT];
  assign src_tick = sysclk_q[dual_timer_pkg::BIT_SRC_SEL] ?
    (fast_clk_tick && fast_osc_enable) : slow_clk_tick;
  always_comb begin
    case (sysclk_q[1:0])
      2'h0: sys_div_lim = dual_timer_pkg::SYS_LIM_DIV8;
      2'h1: sys_div_lim = dual_timer_pkg::SYS_LIM_DIV4;
      2'h2: sys_div_lim = dual_timer_pkg::SYS_LIM_DIV2;
      default: sys_div_lim = dual_timer_pkg::SYS_LIM_DIV1;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sys_div_q <= 3'h0;
      sys_tick <= 1'b0;
    end else begin
      sys_tick <= 1'b0;
      if (src_tick) begin
        if (sys_div_q >= sys_div_lim) begin
          sys_div_q <= 3'h0;
          sys_tick <= 1'b1;
        end else begin
          sys_div_q <= sys_div_q + 3'h1;
        end
      end
    end
  end

  // system clock over two, shared by both timers
  logic half_q;
  logic half_tick;
  always_ff @(posedge aclk) begin
    if (!aresetn) half_q <= 1'b0;
    else if (sys_tick) half_q <= !half_q;
  end
  assign half_tick = sys_tick && half_q;

  // timer0 external pin edge detect
  logic pin_q;
  logic pin_edge;
  always_ff @(posedge aclk) begin
    if (!aresetn) pin_q <= 1'b0;
    else pin_q <= t0_external_clock_pin;
  end
  assign pin_edge = t0_ctrl_q[dual_timer_pkg::BIT_T0_EDGE] ?
    (pin_q && !t0_external_clock_pin) : (!pin_q && t0_external_clock_pin);

  logic [1:0] pre_in;
  logic [3:0] pre_code [2];
  logic [1:0] timer_tick;
  logic [1:0] ovf;
  assign pre_in[0] = t0_ctrl_q[dual_timer_pkg::BIT_T0_SRC] ? pin_edge : half_tick;
  assign pre_in[1] = half_tick;
  assign pre_code[0] = {1'b0, t0_ctrl_q[2:0]};
  assign pre_code[1] = t1_ctrl_q[3] ? dual_timer_pkg::T1_DIV_MAX_CODE : t1_ctrl_q[3:0];

  // per-timer prescaler: divide by 2**code
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_pre
      logic [7:0] cnt_q;
      logic tick_q;
      logic [8:0] lim;
      assign lim = 9'h001 << pre_code[g];
      assign timer_tick[g] = tick_q;
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cnt_q <= 8'h00;
          tick_q <= 1'b0;
        end else begin
          tick_q <= 1'b0;
          if (pre_in[g]) begin
            if ({1'b0, cnt_q} >= lim - 9'h001) begin
              cnt_q <= 8'h00;
              tick_q <= 1'b1;
            end else begin
              cnt_q <= cnt_q + 8'h01;
            end
          end
        end
      end
    end
  endgenerate

  logic t0_run;
  logic t1_run;
  assign t0_run = timer_tick[0] && !t0_ctrl_q[dual_timer_pkg::BIT_T_HALT];
  assign t1_run = timer_tick[1] && !t1_ctrl_q[dual_timer_pkg::BIT_T_HALT];
  assign ovf[0] = t0_run && (t0_count_q == dual_timer_pkg::COUNT_TOP);
  assign ovf[1] = t1_run && (t1_count_q == dual_timer_pkg::COUNT_TOP);

  // counters reload on overflow; a software write of t1_count wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      t0_count_q <= dual_timer_pkg::ZERO8;
      t1_count_q <= dual_timer_pkg::ZERO8;
    end else begin
      if (ovf[0]) t0_count_q <= t0_reload_q;
      else if (t0_run) t0_count_q <= t0_count_q + 8'h01;
      if (wsel(dual_timer_pkg::IDX_T1_COUNT)) t1_count_q <= wdata_q[7:0];
      else if (ovf[1]) t1_count_q <= t1_reload_q;
      else if (t1_run) t1_count_q <= t1_count_q + 8'h01;
    end
  end

  // sticky flags, write one clears, set wins
  logic [1:0] clr;
  // written out in full: a function reading module state would not wake a continuous assign
  assign clr = (wr_hit && (wr_idx == dual_timer_pkg::IDX_IRQ_STATUS) &&
    (aw_idx_q[9:8] == 2'h0)) ? wdata_q[1:0] : 2'h0;
  always_ff @(posedge aclk) begin
    if (!aresetn) irq_status_q <= 2'h0;
    else irq_status_q <= (irq_status_q & ~clr) | ovf;
  end
  assign irq = |(irq_status_q & irq_mask_q);

  // read channel
  logic [7:0] rd_val;
  logic rd_ok;
  always_comb begin
    rd_ok = (s_axi_araddr[11:10] == 2'h0);
    case (s_axi_araddr[9:2])
      dual_timer_pkg::IDX_SYSCLK: rd_val = sysclk_q;
      dual_timer_pkg::IDX_T0_RELOAD: rd_val = t0_reload_q;
      dual_timer_pkg::IDX_T0_CTRL: rd_val = t0_ctrl_q;
      dual_timer_pkg::IDX_T1_COUNT: rd_val = t1_count_q;
      dual_timer_pkg::IDX_T1_RELOAD: rd_val = t1_reload_q;
      dual_timer_pkg::IDX_T1_CTRL: rd_val = t1_ctrl_q;
      dual_timer_pkg::IDX_T0_COUNT: rd_val = t0_count_q;
      dual_timer_pkg::IDX_IRQ_STATUS: rd_val = {6'h00, irq_status_q};
      dual_timer_pkg::IDX_IRQ_MASK: rd_val = {6'h00, irq_mask_q};
      default: begin
        rd_val = 8'h00;
        rd_ok = 1'b0;
      end
    endcase
  end
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= dual_timer_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_val};
      s_axi_rresp <= rd_ok ? dual_timer_pkg::RESP_OKAY : dual_timer_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // assertions
  property p_fast_halt;
    @(posedge aclk) disable iff (!aresetn)
      sysclk_q[dual_timer_pkg::BIT_FAST_HALT] && sysclk_q[dual_timer_pkg::BIT_SRC_SEL]
        |=> !sys_tick;
  endproperty
  a_fast_halt: assert property (p_fast_halt) else $error("fast osc runs while halted");
  property p_src;
    @(posedge aclk) disable iff (!aresetn)
      (sysclk_q[2] == 1'b0 && !slow_clk_tick) |=> !sys_tick;
  endproperty
  a_src: assert property (p_src) else $error("sys tick without slow tick");
  property p_div1;
    @(posedge aclk) disable iff (!aresetn)
      (sysclk_q[1:0] == 2'h3 && src_tick) |=> sys_tick;
  endproperty
  a_div1: assert property (p_div1) else $error("divide by one missed");
  property p_reload;
    @(posedge aclk) disable iff (!aresetn) ovf[0] |=> (t0_count_q == $past(t0_reload_q));
  endproperty
  a_reload: assert property (p_reload) else $error("timer0 reload wrong");
  property p_ext;
    @(posedge aclk) disable iff (!aresetn)
      t0_ctrl_q[dual_timer_pkg::BIT_T0_SRC] && !pin_edge |=> !timer_tick[0];
  endproperty
  a_ext: assert property (p_ext) else $error("timer0 counts without pin edge");
  property p_t1_src;
    @(posedge aclk) disable iff (!aresetn) !half_tick |=> !timer_tick[1];
  endproperty
  a_t1_src: assert property (p_t1_src) else $error("timer1 tick without source");
  property p_t0_flag;
    @(posedge aclk) disable iff (!aresetn) ovf[0] |=> irq_status_q[dual_timer_pkg::BIT_IRQ_T0];
  endproperty
  a_t0_flag: assert property (p_t0_flag) else $error("timer0 flag not set");
  property p_t1_flag;
    @(posedge aclk) disable iff (!aresetn) ovf[1] |=> irq_status_q[dual_timer_pkg::BIT_IRQ_T1];
  endproperty
  a_t1_flag: assert property (p_t1_flag) else $error("timer1 flag not set");
  property p_halt;
    @(posedge aclk) disable iff (!aresetn)
      t0_ctrl_q[dual_timer_pkg::BIT_T_HALT] |=> $stable(t0_count_q);
  endproperty
  a_halt: assert property (p_halt) else $error("halted timer0 moved");
  c_t0_ovf: cover property (@(posedge aclk) disable iff (!aresetn) ovf[0]);
  c_t1_ovf: cover property (@(posedge aclk) disable iff (!aresetn) ovf[1]);
  c_irq: cover property (@(posedge aclk) disable iff (!aresetn) irq);
endmodule : dual_timer
`default_nettype wire

/* File: dual_timer_tb.sv */
// Purpose: self-checking bench of the dual timer with clock select
// Assumes: fast source ticks each cycle while enabled, slow source every fourth cycle
// Notes: bus tasks note expectations in queues, a monitor compares them as answers come
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((e) !== (g)) begin n_mismatch++; \
  $display("unexpected %s expected %0h seen %0h", n, e, g); end end
module dual_timer_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] SC = dual_timer_pkg::IDX_SYSCLK, R0 = dual_timer_pkg::IDX_T0_RELOAD;
  localparam logic [7:0] C0 = dual_timer_pkg::IDX_T0_CTRL, N1 = dual_timer_pkg::IDX_T1_COUNT;
  localparam logic [7:0] R1 = dual_timer_pkg::IDX_T1_RELOAD, C1 = dual_timer_pkg::IDX_T1_CTRL;
  localparam logic [7:0] N0 = dual_timer_pkg::IDX_T0_COUNT, ST = dual_timer_pkg::IDX_IRQ_STATUS;
  localparam logic [7:0] MK = dual_timer_pkg::IDX_IRQ_MASK;
  typedef struct {logic [31:0] lo; logic [31:0] hi; logic [1:0] rs;} note_t;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
  logic slow_on = 0, slow_t = 0, fast_t = 0, pin = 0;
  logic [3:0] ws = 4'hF;
  logic [11:0] aw = 0, ar = 0;
  logic [31:0] wd = 0;
  logic [1:0] div_c = 0, eb;
  logic [7:0] c0, rv8;
  logic [7:0] rz [7] = '{R0, C0, N1, R1, C1, ST, MK};
  wire logic awr, wrdy, bv, arr, rv, fen, stk, irq;
  wire logic [1:0] br, rr;
  wire logic [31:0] rd;
  int n_mismatch = 0, checks_done = 0, cyc = 0, gap = 1, tick_gap = 0;
  note_t rq[$], n;
  logic [1:0] wq[$];
  dual_timer dual_timer_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wrdy), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
    .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre), .slow_clk_tick(slow_t),
    .fast_clk_tick(fast_t), .t0_external_clock_pin(pin), .fast_osc_enable(fen),
    .sys_tick(stk), .irq(irq));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run
  task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic [1:0] e = 2'h0);
    bit a = 0;
    bit w = 0;
    wq.push_back(e);
    aw <= {2'h0, i, 2'h0};
    wd <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    while (!(a && w)) begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
      a |= awr;
      w |= wrdy;
    end
    do @(posedge aclk); while (bv !== 1'b1);
    bre <= 1'b0;
    @(posedge aclk);
  endtask : wr
  task automatic rda(input logic [7:0] i, input logic [31:0] lo, input logic [31:0] hi,
      input logic [1:0] e, output logic [7:0] v);
    rq.push_back('{lo, hi, e});
    ar <= {2'h0, i, 2'h0};
    arv <= 1'b1;
    rre <= 1'b1;
    do @(posedge aclk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge aclk); while (rv !== 1'b1);
    v = rd[7:0];
    rre <= 1'b0;
    @(posedge aclk);
  endtask : rda
  task automatic chk(input logic [7:0] i, input logic [7:0] e);
    logic [7:0] v;
    rda(i, {24'h0, e}, {24'h0, e}, 2'h0, v);
  endtask : chk
  // sample spacing is exactly 16 periods, so phase leaves at most one tick either way
  task automatic rate(input logic [7:0] i, input int p);
    logic [7:0] a, b, d;
    repeat (p) @(posedge aclk);
    rda(i, 32'h0, 32'hFF, 2'h0, a);
    repeat (16 * p - 3) @(posedge aclk);
    rda(i, 32'h0, 32'hFF, 2'h0, b);
    d = b - a;
    `CHK("ticks", 8'h10, (d >= 8'h0F && d <= 8'h11) ? 8'h10 : d)
  endtask : rate
  task automatic flag(input logic e);
    #1;
    `CHK("irq", e, irq)
  endtask : flag
  always #12.5 aclk = ~aclk;
  always @(posedge aclk) begin
    div_c <= div_c + 2'h1;
    slow_t <= slow_on && div_c == 2'h0;
    fast_t <= fen === 1'b1;
    gap <= (stk === 1'b1) ? 1 : gap + 1;
    if (stk === 1'b1) tick_gap <= gap;
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      complete_run();
    end
  end
  always @(posedge aclk) begin
    if (bv && bre) begin
      eb = wq.pop_front();
      `CHK("bresp", eb, br)
    end
    if (rv && rre) begin
      n = rq.pop_front();
      `CHK("rresp", n.rs, rr)
      `CHK("rdata", n.lo, (rd >= n.lo && rd <= n.hi) ? n.lo : rd)
    end
  end
  initial begin
    void'($urandom(42));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    flag(1'b0);
    `CHK("fast_en", 1'b0, fen)
    chk(SC, 8'h0B);
    for (int k = 0; k < 7; k++) chk(rz[k], 8'h00);
    rda(8'h30, 32'h0, 32'h0, 2'h2, c0);
    wr(8'h30, 8'h5A, 2'h2);
    rv8 = 8'($urandom);
    wr(R0, rv8);
    chk(R0, rv8);
    ws <= 4'h0;
    wr(R0, ~rv8);
    ws <= 4'hF;
    chk(R0, rv8);
    wr(R1, ~rv8);
    chk(R1, ~rv8);
    wr(R0, 8'h00);
    wr(R1, 8'h00);
    $display("test registers done");
    wr(SC, 8'h03);
    #1;
    `CHK("fast_en", 1'b1, fen)
    slow_on <= 1'b1;
    for (int s = 0; s < 2; s++) begin
      for (int c = 0; c < 4; c++) begin
        wr(SC, 8'(s * 4 + c));
        repeat (100) @(posedge aclk);
        `CHK("sys_period", (s ? 1 : 4) * (8 >> c), tick_gap)
      end
    end
    wr(SC, 8'h0F);
    #1;
    `CHK("fast_en", 1'b0, fen)
    wr(SC, 8'h07);
    $display("test system clock done");
    for (int c = 0; c < 9; c++) begin
      wr(C1, c == 8 ? 8'h0F : 8'(c));
      rate(N1, 2 << c);
    end
    for (int c = 0; c < 8; c++) begin
      wr(C0, 8'(c));
      rate(N0, 2 << c);
    end
    $display("test prescalers done");
    rv8 = 8'($urandom);
    wr(C1, 8'h40);
    wr(N1, rv8);
    wr(C0, 8'h40);
    rda(N0, 32'h0, 32'hFF, 2'h0, c0);
    repeat (40) @(posedge aclk);
    chk(N1, rv8);
    chk(N0, c0);
    $display("test halt done");
    for (int e = 0; e < 2; e++) begin
      wr(C0, e ? 8'h30 : 8'h10);
      // a prescaler tick left from the old source may land as the halt lifts
      if (e == 0) rda(N0, 32'h0, 32'hFF, 2'h0, c0);
      pin <= 1'b1;
      repeat (6) @(posedge aclk);
      chk(N0, c0 + 8'h01);
      pin <= 1'b0;
      repeat (6) @(posedge aclk);
      chk(N0, c0 + 8'(e + 1));
    end
    $display("test external clock done");
    wr(R0, 8'hFF);
    wr(C0, 8'h00);
    repeat (600) @(posedge aclk);
    wr(ST, 8'h03);
    repeat (20) @(posedge aclk);
    chk(ST, 8'h01);
    flag(1'b0);
    wr(MK, 8'h01);
    flag(1'b1);
    wr(N1, 8'hFF);
    wr(C1, 8'h00);
    repeat (20) @(posedge aclk);
    chk(ST, 8'h03);
    wr(C1, 8'h40);
    wr(MK, 8'h02);
    flag(1'b1);
    wr(ST, 8'h02);
    chk(ST, 8'h01);
    flag(1'b0);
    chk(MK, 8'h02);
    $display("test interrupts done");
    complete_run();
  end
endmodule : dual_timer_tb
`default_nettype wire
